// ---- loader_pkg.sv ----
package loader_pkg;

	// clocking and timing
	localparam int CLK_HZ      = 50_000_000;
	localparam int MS_PER_S    = 1000;
	localparam int CYC_PER_MS  = CLK_HZ / MS_PER_S;
	localparam int I2C_HZ      = 100_000;
	localparam int I2C_QTR     = CLK_HZ / (4 * I2C_HZ);
	localparam logic [7:0] RELEASE_DELAY_MS = 8'h14; // 20 ms

	// own register map, byte offsets
	localparam logic [7:0] CTRL_OFS  = 8'h00;
	localparam logic [7:0] STAT_OFS  = 8'h04;
	localparam logic [7:0] DELAY_OFS = 8'h08;

	// control fields
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_GO_BIT = 1;
	localparam logic CTRL_EN_RST = 1'b1;

	// status fields
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DONE_BIT = 1;
	localparam int STAT_ERR_BIT  = 2;
	localparam int STAT_REL_BIT  = 3;
	localparam int STAT_RAIL_BIT = 4;
	localparam int STAT_CAM_BIT  = 5;
	localparam int STAT_IDX_LSB  = 8;

	// target addresses, 7-bit form
	localparam logic [6:0] DES_ADDR7 = 7'h30;
	localparam logic [6:0] SER_ADDR7 = 7'h58;
	localparam logic [6:0] IMG_ADDR7 = 7'h20;

	typedef struct packed {
		logic [6:0] dev;
		logic [7:0] regad;
		logic [7:0] val;
	} cfg_entry_t;

	localparam int CFG_N = 7;
	localparam cfg_entry_t CFG_TABLE [CFG_N] = '{
		'{DES_ADDR7, 8'h4c, 8'h01},
		'{DES_ADDR7, 8'h58, 8'h58},
		'{DES_ADDR7, 8'h5c, 8'hb0},
		'{DES_ADDR7, 8'h5d, 8'h20},
		'{DES_ADDR7, 8'h65, 8'h20},
		'{DES_ADDR7, 8'h6d, 8'h7e},
		'{SER_ADDR7, 8'h0d, 8'h99}
	};

	typedef struct packed {
		logic        start;
		logic        stop;
		logic [7:0]  data;
	} i2c_cmd_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} apb_rsp_t;

endpackage

// ---- i2c_byte_engine.sv ----
`timescale 1ns/1ps
module i2c_byte_engine
#(
	parameter int QTR = loader_pkg::I2C_QTR
)
(
	input  wire logic                 mclk,
	input  wire logic                 nrst,
	input  wire loader_pkg::i2c_cmd_t cmd,
	input  wire logic                 cmd_valid,
	output logic                      cmd_ready,
	output logic                      done,
	output logic                      nack,
	input  wire logic                 scl_i,
	output logic                      scl_o,
	output logic                      scl_oe,
	input  wire logic                 sda_i,
	output logic                      sda_o,
	output logic                      sda_oe
);
	import loader_pkg::*;

	typedef enum {E_IDLE, E_START, E_BIT, E_STOP} eng_st_t;

	if (QTR < 2 || QTR > 65535)
	begin : g_chk
		$error("i2c quarter period out of range");
	end

	eng_st_t     st_q;
	logic [1:0]  ph_q;
	logic [15:0] tmr_q;
	logic [3:0]  bit_q;
	logic [8:0]  sh_q;
	logic        stop_q;
	logic        nack_q;
	logic        scl_oe_q;
	logic        sda_oe_q;
	logic        done_q;
	logic        scl_m_q;
	logic        scl_s_q;
	logic        sda_m_q;
	logic        sda_s_q;
	logic        tick;

	// open drain: pins only ever pulled low
	assign scl_o     = 1'b0;
	assign sda_o     = 1'b0;
	assign scl_oe    = scl_oe_q;
	assign sda_oe    = sda_oe_q;
	assign done      = done_q;
	assign nack      = nack_q;
	assign cmd_ready = (st_q == E_IDLE);
	assign tick      = (tmr_q == 16'(QTR - 1));

	// pin synchronisers
	always_ff @(posedge mclk)
	begin
		scl_m_q <= scl_i;
		scl_s_q <= scl_m_q;
		sda_m_q <= sda_i;
		sda_s_q <= sda_m_q;
	end

	// quarter bit timer, idle while nothing is in flight
	always_ff @(posedge mclk)
	begin
		if (!nrst || st_q == E_IDLE)
			tmr_q <= '0;
		else
			tmr_q <= tick ? '0 : tmr_q + 16'h0001;
	end

	// bit sequencer; a refused byte always ends the transfer with a stop
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			st_q     <= E_IDLE;
			ph_q     <= 2'h0;
			bit_q    <= 4'h0;
			sh_q     <= '1;
			stop_q   <= 1'b0;
			nack_q   <= 1'b0;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
			done_q   <= 1'b0;
		end
		else
		begin
			done_q <= 1'b0;
			case (st_q)
			E_IDLE:
				if (cmd_valid)
				begin
					sh_q   <= {cmd.data, 1'b1}; // ninth bit released for ack
					bit_q  <= 4'h0;
					ph_q   <= 2'h0;
					stop_q <= cmd.stop;
					nack_q <= 1'b0;
					st_q   <= cmd.start ? E_START : E_BIT;
				end
			E_START:
				if (tick)
				begin
					if (ph_q == 2'h0)
					begin
						sda_oe_q <= 1'b1; // sda falls while scl high
						ph_q     <= 2'h1;
					end
					else
					begin
						scl_oe_q <= 1'b1;
						ph_q     <= 2'h0;
						st_q     <= E_BIT;
					end
				end
			E_BIT:
				if (tick)
				begin
					case (ph_q)
					2'h0:
					begin
						sda_oe_q <= ~sh_q[8];
						ph_q     <= 2'h1;
					end
					2'h1:
					begin
						scl_oe_q <= 1'b0;
						ph_q     <= 2'h2;
					end
					2'h2:
						if (scl_s_q) // waits while the target stretches scl
						begin
							if (bit_q == 4'h8)
								nack_q <= sda_s_q; // RQ14
							ph_q <= 2'h3;
						end
					default:
					begin
						scl_oe_q <= 1'b1;
						ph_q     <= 2'h0;
						if (bit_q == 4'h8)
						begin
							if (stop_q || nack_q) // RQ14
								st_q <= E_STOP;
							else
							begin
								done_q <= 1'b1;
								st_q   <= E_IDLE;
							end
						end
						else
						begin
							bit_q <= bit_q + 4'h1;
							sh_q  <= {sh_q[7:0], 1'b1};
						end
					end
					endcase
				end
			E_STOP:
				if (tick)
				begin
					case (ph_q)
					2'h0: sda_oe_q <= 1'b1;
					2'h1: scl_oe_q <= 1'b0;
					2'h2: sda_oe_q <= 1'b0; // sda rises while scl high
					default:
					begin
						done_q <= 1'b1;
						st_q   <= E_IDLE;
					end
					endcase
					ph_q <= ph_q + 2'h1;
				end
			default:
				st_q <= E_IDLE;
			endcase
		end
	end

endmodule

// ---- camera_link_loader.sv ----
// Operation
// RQ1 - Every deserializer write goes to 7-bit address 0x30, sent as 0x60 with the write bit.
// RQ2 - The first deserializer write puts 0x01 into register 0x4c to open port zero for writes.
// RQ3 - Register 0x58 of the deserializer gets 0x58 to pass transactions through the link.
// RQ4 - Register 0x5c of the deserializer gets 0xb0, the alias of the remote serializer.
// RQ5 - Register 0x5d of the deserializer gets 0x20, the real address of the remote imager.
// RQ6 - Register 0x65 of the deserializer gets 0x20, the local alias of the imager.
// RQ7 - Register 0x6d of the deserializer gets 0x7e for coax cabling and raw 12-bit mode.
// RQ8 - After the deserializer, writes go to the serializer at 7-bit 0x58, sent as 0xb0.
// RQ9 - Register 0x0d of the serializer gets 0x99 to set its outputs and lock out remote control.
// RQ10 - No configuration write starts before all three parts are powered.
// RQ11 - The power-down release stays low until every supply rail has settled.
// RQ12 - The release rises about 20 ms after the rail is stable, the delay adjustable and shorter allowed.
// RQ13 - An acknowledged write to the imager alias confirms the imager is present.
// RQ14 - Each write is address, register byte, data byte; an unacknowledged byte stops and flags error.
//        The imager probe sends the address byte alone, and a refusal there ends in done, not error.
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps
module camera_link_loader
#(
	parameter int CYC_PER_MS_P = loader_pkg::CYC_PER_MS,
	parameter int I2C_QTR_P    = loader_pkg::I2C_QTR
)
(
	input  wire logic                 mclk,
	input  wire logic                 nrst,
	input  wire loader_pkg::apb_req_t apb_req,
	output loader_pkg::apb_rsp_t      apb_rsp,
	input  wire logic                 rails_ok,
	output logic                      link_powerdown_release,
	input  wire logic                 scl_i,
	output logic                      scl_o,
	output logic                      scl_oe,
	input  wire logic                 sda_i,
	output logic                      sda_o,
	output logic                      sda_oe
);
	import loader_pkg::*;

	typedef enum {M_OFF, M_WAIT, M_LOAD, M_PROBE, M_DONE, M_ERR} main_st_t;

	if (CYC_PER_MS_P < 1 || CYC_PER_MS_P > 65535)
	begin : g_chk
		$error("cycles per millisecond out of range");
	end

	main_st_t    st_q;
	logic [2:0]  idx_q;
	logic [1:0]  step_q;
	logic        pend_q;
	logic        cam_ok_q;
	logic [2:0]  fail_q;
	logic        rel_q;
	logic        rails_m_q;
	logic        rails_q;
	logic [15:0] cyc_q;
	logic [7:0]  ms_q;
	logic [7:0]  dly_ms_q;
	logic        en_q;
	logic [31:0] prdata_q;
	logic        pslverr_q;
	logic        up_w;
	logic        go_w;
	logic        wr_w;
	logic        setup_w;
	logic        eng_valid;
	logic        eng_ready;
	logic        eng_done;
	logic        eng_nack;
	i2c_cmd_t    eng_cmd;
	cfg_entry_t  ent;
	logic [31:0] stat_w;

	i2c_byte_engine #(
		.QTR (I2C_QTR_P)
	) u_eng (
		.mclk      (mclk),
		.nrst      (nrst),
		.cmd       (eng_cmd),
		.cmd_valid (eng_valid),
		.cmd_ready (eng_ready),
		.done      (eng_done),
		.nack      (eng_nack),
		.scl_i     (scl_i),
		.scl_o     (scl_o),
		.scl_oe    (scl_oe),
		.sda_i     (sda_i),
		.sda_o     (sda_o),
		.sda_oe    (sda_oe)
	);

	// rail indicator comes from a pin
	always_ff @(posedge mclk)
	begin
		rails_m_q <= rails_ok;
		rails_q   <= rails_m_q;
	end

	assign up_w = rails_q && en_q;
	assign link_powerdown_release = rel_q;

	// settle delay in whole milliseconds, counted only while waiting
	always_ff @(posedge mclk)
	begin
		if (!nrst || st_q != M_WAIT)
		begin
			cyc_q <= '0;
			ms_q  <= '0;
		end
		else if (ms_q != dly_ms_q)
		begin
			if (cyc_q == 16'(CYC_PER_MS_P - 1))
			begin
				cyc_q <= '0;
				ms_q  <= ms_q + 8'h01;
			end
			else
				cyc_q <= cyc_q + 16'h0001;
		end
	end

	// release held low until rails settle and the delay has run out
	always_ff @(posedge mclk)
	begin
		if (!nrst)
			rel_q <= 1'b0;
		else
			rel_q <= up_w && (st_q == M_LOAD || st_q == M_PROBE || st_q == M_DONE // RQ11
				|| st_q == M_ERR || (st_q == M_WAIT && ms_q == dly_ms_q)); // RQ12
	end

	// byte to send for the current entry and step
	always_comb
	begin
		ent = CFG_TABLE[idx_q];
		eng_cmd = '{start: 1'b0, stop: 1'b0, data: ent.regad}; // RQ14
		if (st_q == M_PROBE)
			eng_cmd = '{start: 1'b1, stop: 1'b1, data: {IMG_ADDR7, 1'b0}}; // RQ13
		else if (step_q == 2'h0)
			eng_cmd = '{start: 1'b1, stop: 1'b0, data: {ent.dev, 1'b0}}; // RQ1 RQ8
		else if (step_q == 2'h2)
			eng_cmd = '{start: 1'b0, stop: 1'b1, data: ent.val}; // RQ2 RQ9
	end

	// nothing leaves before the link is released
	assign eng_valid = (st_q == M_LOAD || st_q == M_PROBE) && !pend_q && up_w && rel_q; // RQ10

	// one byte in flight at a time
	always_ff @(posedge mclk)
	begin
		if (!nrst)
			pend_q <= 1'b0;
		else if (eng_valid && eng_ready)
			pend_q <= 1'b1;
		else if (eng_done)
			pend_q <= 1'b0;
	end

	// sequencer over the table, then the imager probe
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			st_q     <= M_OFF;
			idx_q    <= 3'h0;
			step_q   <= 2'h0;
			cam_ok_q <= 1'b0;
			fail_q   <= 3'h0;
		end
		else if (!up_w)
			st_q <= M_OFF; // RQ10
		else
		begin
			case (st_q)
			M_OFF:
				st_q <= M_WAIT;
			M_WAIT:
				if (ms_q == dly_ms_q)
				begin
					idx_q    <= 3'h0;
					step_q   <= 2'h0;
					cam_ok_q <= 1'b0;
					st_q     <= M_LOAD;
				end
			M_LOAD:
				if (eng_done && pend_q)
				begin
					if (eng_nack)
					begin
						fail_q <= idx_q;
						st_q   <= M_ERR; // RQ14
					end
					else if (step_q == 2'h2)
					begin
						step_q <= 2'h0;
						if (idx_q == 3'(CFG_N - 1))
							st_q <= M_PROBE;
						else
							idx_q <= idx_q + 3'h1; // RQ3 RQ4 RQ5 RQ6 RQ7
					end
					else
						step_q <= step_q + 2'h1;
				end
			M_PROBE:
				if (eng_done && pend_q)
				begin
					cam_ok_q <= !eng_nack; // RQ13
					st_q     <= M_DONE;
				end
			M_DONE, M_ERR:
				if (go_w && !pend_q)
				begin
					idx_q    <= 3'h0;
					step_q   <= 2'h0;
					cam_ok_q <= 1'b0;
					st_q     <= M_LOAD;
				end
			default:
				st_q <= M_OFF;
			endcase
		end
	end

	// apb slave: reads decoded in setup, writes in access, answer with no wait state
	assign setup_w = apb_req.psel && !apb_req.penable;
	assign wr_w    = apb_req.psel && apb_req.penable && apb_req.pwrite;
	assign go_w    = wr_w && apb_req.paddr == CTRL_OFS && apb_req.pwdata[CTRL_GO_BIT];
	assign apb_rsp = '{pready: 1'b1, pslverr: pslverr_q, prdata: prdata_q};

	always_comb
	begin
		stat_w = '0;
		stat_w[STAT_BUSY_BIT] = (st_q == M_WAIT || st_q == M_LOAD || st_q == M_PROBE);
		stat_w[STAT_DONE_BIT] = (st_q == M_DONE);
		stat_w[STAT_ERR_BIT]  = (st_q == M_ERR);
		stat_w[STAT_REL_BIT]  = rel_q;
		stat_w[STAT_RAIL_BIT] = rails_q;
		stat_w[STAT_CAM_BIT]  = cam_ok_q;
		stat_w[STAT_IDX_LSB +: 3] = fail_q;
	end

	// read data and error captured in setup, so outputs come from flops
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			prdata_q  <= '0;
			pslverr_q <= 1'b0;
		end
		else if (setup_w)
		begin
			pslverr_q <= 1'b0;
			case (apb_req.paddr)
			CTRL_OFS:  prdata_q <= {30'h0, 1'b0, en_q};
			STAT_OFS:  prdata_q <= stat_w;
			DELAY_OFS: prdata_q <= {24'h0, dly_ms_q};
			default:
			begin
				prdata_q  <= '0;
				pslverr_q <= 1'b1;
			end
			endcase
		end
	end

	// writable settings
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			en_q     <= CTRL_EN_RST;
			dly_ms_q <= RELEASE_DELAY_MS;
		end
		else if (wr_w && apb_req.paddr == CTRL_OFS)
			en_q <= apb_req.pwdata[CTRL_EN_BIT];
		else if (wr_w && apb_req.paddr == DELAY_OFS && st_q != M_WAIT)
			dly_ms_q <= apb_req.pwdata[7:0]; // RQ12
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	a_release_rails_low: assert property (!rails_q |=> !rel_q) // RQ11
		else $error("release high while rails not settled");
	// a start condition is sda pulled low while scl is left high
	a_no_early_write: assert property ($rose(sda_oe) && !scl_oe |-> rel_q && rails_q) // RQ10
		else $error("start condition before power up");
	a_release_after_delay: assert property ($rose(rel_q) |-> $past(st_q) == M_WAIT // RQ12
		&& $past(ms_q) == $past(dly_ms_q))
		else $error("release rose before the delay ran out");
	a_des_first_addr: assert property (eng_valid && st_q == M_LOAD && step_q == 2'h0 // RQ1
		&& idx_q < 3'h6 |-> eng_cmd.data == 8'h60 && eng_cmd.start)
		else $error("deserializer address wrong");
	a_port_write_en: assert property (eng_valid && st_q == M_LOAD && idx_q == 3'h0 // RQ2
		&& step_q != 2'h0 |-> eng_cmd.data == (step_q == 2'h1 ? 8'h4c : 8'h01))
		else $error("port enable value wrong");
	a_pass_through: assert property (eng_valid && idx_q == 3'h1 && step_q == 2'h2 // RQ3
		&& st_q == M_LOAD |-> eng_cmd.data == 8'h58 && eng_cmd.stop)
		else $error("passthrough value wrong");
	a_ser_alias: assert property (eng_valid && idx_q == 3'h2 && step_q == 2'h1 // RQ4
		&& st_q == M_LOAD |-> eng_cmd.data == 8'h5c)
		else $error("serializer alias register wrong");
	a_img_id: assert property (eng_valid && idx_q == 3'h3 && step_q == 2'h1 // RQ5
		&& st_q == M_LOAD |-> eng_cmd.data == 8'h5d)
		else $error("imager id register wrong");
	a_img_alias: assert property (eng_valid && idx_q == 3'h4 && step_q == 2'h2 // RQ6
		&& st_q == M_LOAD |-> eng_cmd.data == 8'h20)
		else $error("imager alias value wrong");
	a_coax_mode: assert property (eng_valid && idx_q == 3'h5 && step_q == 2'h2 // RQ7
		&& st_q == M_LOAD |-> eng_cmd.data == 8'h7e)
		else $error("coax mode value wrong");
	a_ser_addr: assert property (eng_valid && idx_q == 3'h6 && step_q == 2'h0 // RQ8
		&& st_q == M_LOAD |-> eng_cmd.data == 8'hb0 && eng_cmd.start)
		else $error("serializer address wrong");
	a_ser_outputs: assert property (eng_valid && idx_q == 3'h6 && step_q == 2'h2 // RQ9
		&& st_q == M_LOAD |-> eng_cmd.data == 8'h99 && eng_cmd.stop)
		else $error("serializer output value wrong");
	a_probe_ack: assert property (st_q == M_PROBE && eng_done && pend_q && up_w // RQ13
		|=> st_q == M_DONE && cam_ok_q == !$past(eng_nack))
		else $error("imager presence not recorded");
	a_nack_stops: assert property (st_q == M_LOAD && eng_done && pend_q && eng_nack // RQ14
		&& up_w |=> st_q == M_ERR && fail_q == $past(idx_q))
		else $error("refused byte did not stop the load");

	c_load_done: cover property (st_q == M_PROBE ##[1:1000] st_q == M_DONE);
	c_load_error: cover property (st_q == M_LOAD ##1 st_q == M_ERR);
	c_imager_seen: cover property ($rose(cam_ok_q));
	c_release: cover property ($rose(rel_q));

endmodule

// ---- cam_link_far_model.sv ----
`timescale 1ns/1ps
// far side: deserializer registers, serializer and imager behind aliases
module cam_link_far_model
(
	input  wire logic       scl,
	input  wire logic       sda,
	input  wire logic       powered,
	input  wire logic       img_present,
	input  wire logic [6:0] refuse_dev,
	output logic            sda_oe
);
	logic [7:0]  des_q [256];
	logic [22:0] wlog [$];
	logic [7:0]  sh;
	logic [6:0]  dev;
	logic [7:0]  regad;
	logic        ser_up;
	logic        img_up;
	logic        hit;
	int          nb;
	int          bi;

	// remote parts only answer once the link setup is in place
	assign ser_up = des_q[8'h4c] == 8'h01 && des_q[8'h58] == 8'h58 && des_q[8'h5c] == 8'hb0;
	assign img_up = img_present && des_q[8'h5d] == 8'h20 && des_q[8'h65] == 8'h20;

	initial
	begin
		sda_oe = 1'b0;
		nb = 0;
		bi = 9;
		foreach (des_q[i])
			des_q[i] = 8'h00;
	end

	// start: sda falls while scl is high
	always @(negedge sda)
		if (scl)
		begin
			nb = 0;
			bi = 0;
		end

	// shift in on rising scl
	always @(posedge scl)
	begin
		sh = {sh[6:0], sda};
		nb = nb + 1;
	end

	// ack slot opens and closes on falling scl, so data never moves while scl is high
	always @(negedge scl)
	begin
		if (nb == 9)
		begin
			sda_oe = 1'b0;
			nb = 0;
			bi = bi + 1;
		end
		else if (nb == 8 && bi < 3)
		begin
			if (bi == 0)
				dev = sh[7:1];
			else if (bi == 1)
				regad = sh;
			else
			begin
				wlog.push_back({dev, regad, sh});
				if (dev == 7'h30)
					des_q[regad] = sh;
			end
			hit = dev == 7'h30 || (dev == 7'h58 && ser_up) || (dev == 7'h20 && img_up);
			sda_oe = powered && dev != refuse_dev && (bi > 0 || (!sh[0] && hit));
			if (!sda_oe)
				bi = 9;
		end
	end
endmodule

// ---- test_camera_link_bringup_loader.sv ----
`timescale 1ns/1ps
module test_camera_link_bringup_loader;
	import loader_pkg::*;
	apb_req_t    req;
	apb_rsp_t    rsp;
	logic        mclk;
	logic        nrst;
	logic        rails_ok;
	logic        img_present;
	logic [6:0]  refuse_dev;
	logic        scl_oe;
	logic        sda_oe;
	logic        far_oe;
	logic        rel_w;
	logic [1:0]  pin_o;
	logic [31:0] rd;
	logic        er;
	int          errors;
	int          n_compared;
	int          n;
	int          early;
	// open-drain wires with pull-ups
	wire         scl_w = scl_oe ? 1'b0 : 1'b1;
	wire         sda_w = (sda_oe || far_oe) ? 1'b0 : 1'b1;
	logic [22:0] exp_log [7] = '{
		{7'h30, 8'h4c, 8'h01},
		{7'h30, 8'h58, 8'h58},
		{7'h30, 8'h5c, 8'hb0},
		{7'h30, 8'h5d, 8'h20},
		{7'h30, 8'h65, 8'h20},
		{7'h30, 8'h6d, 8'h7e},
		{7'h58, 8'h0d, 8'h99}
	};

	camera_link_loader #(.CYC_PER_MS_P(10), .I2C_QTR_P(4)) u_camera_link_loader
	(
		.mclk(mclk), .nrst(nrst), .apb_req(req), .apb_rsp(rsp), .rails_ok(rails_ok),
		.link_powerdown_release(rel_w), .scl_i(scl_w), .scl_o(pin_o[1]), .scl_oe(scl_oe),
		.sda_i(sda_w), .sda_o(pin_o[0]), .sda_oe(sda_oe)
	);

	cam_link_far_model u_cam_link_far_model
	(
		.scl(scl_w), .sda(sda_w), .powered(rails_ok), .img_present(img_present),
		.refuse_dev(refuse_dev), .sda_oe(far_oe)
	);

	initial
	begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	// any bus activity while the link is held down is premature
	always @(negedge sda_w)
		if (rel_w !== 1'b1)
			early++;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one transfer; idle cycle after it so psel is never assigned twice in a step
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		req <= '{1'b1, 1'b0, wr, a, d};
		@(posedge mclk);
		req.penable <= 1'b1;
		@(posedge mclk);
		while (rsp.pready !== 1'b1)
			@(posedge mclk);
		rd = rsp.prdata;
		er = rsp.pslverr;
		req <= '0;
		@(posedge mclk);
	endtask

	// poll status until done or error
	task automatic wait_end;
		n = 0;
		do
		begin
			apb(1'b0, 8'h04, 32'h0);
			n++;
		end
		while (rd[1] !== 1'b1 && rd[2] !== 1'b1 && n < 3000);
		// a load that never ends is a failure in its own right
		if (n >= 3000)
		begin
			errors++;
			test_done;
		end
	endtask

	task automatic test_done;
		$display("compared %0d, errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial
	begin
		repeat (60000) @(posedge mclk);
		errors++;
		test_done;
	end

	initial
	begin
		errors = 0;
		n_compared = 0;
		early = 0;
		nrst = 1'b0;
		rails_ok = 1'b0;
		img_present = 1'b1;
		refuse_dev = 7'h7f;
		req = '0;
		repeat (6) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h1);
		apb(1'b0, 8'h08, 32'h0);
		chk(rd, 32'h14);
		apb(1'b0, 8'h0c, 32'h0);
		chk({er, rd[30:0]}, 32'h80000000);
		apb(1'b1, 8'h08, 32'h3);
		repeat (50) @(posedge mclk);
		chk(rel_w, 1'b0);
		rails_ok <= 1'b1;
		n = 0;
		while (rel_w !== 1'b1 && n < 500)
		begin
			@(posedge mclk);
			n++;
		end
		chk(n >= 30 && n <= 38, 1);
		wait_end;
		chk(rd & 32'h3f, 32'h3a);
		chk(u_cam_link_far_model.wlog.size(), 7);
		foreach (exp_log[i])
			chk(u_cam_link_far_model.wlog[i], exp_log[i]);
		// imager absent: probe refused, not an error
		img_present <= 1'b0;
		apb(1'b1, 8'h00, 32'h3);
		wait_end;
		chk(rd & 32'h3f, 32'h1a);
		chk(u_cam_link_far_model.wlog[7], exp_log[0]);
		// refused serializer then refused deserializer
		for (int k = 0; k < 2; k++)
		begin
			refuse_dev <= k ? 7'h30 : 7'h58;
			apb(1'b1, 8'h00, 32'h3);
			wait_end;
			chk(rd & 32'h71f, k ? 32'h01c : 32'h61c);
		end
		refuse_dev <= 7'h7f;
		rails_ok <= 1'b0;
		repeat (6) @(posedge mclk);
		chk(rel_w, 1'b0);
		rails_ok <= 1'b1;
		repeat (4) @(posedge mclk);
		// delay change refused while settling
		apb(1'b1, 8'h08, 32'hc8);
		apb(1'b0, 8'h08, 32'h0);
		chk(rd, 32'h3);
		wait_end;
		chk(rd & 32'h3f, 32'h1a);
		apb(1'b1, 8'h00, 32'h0);
		repeat (4) @(posedge mclk);
		chk(rel_w, 1'b0);
		chk(early, 0);
		chk(pin_o, 32'h0);
		test_done;
	end
endmodule
